/* File: ccil_consts.svh */
`ifndef CCIL_CONSTS_SVH
`define CCIL_CONSTS_SVH

`define CCIL_ADR_INDICATOR 4'h0
`define CCIL_ADR_LATCHES   4'h4
`define CCIL_ADR_CONTROL   4'h8

`define CCIL_IND_FAULT_BIT   0
`define CCIL_IND_REFUSED_BIT 2

`define CCIL_LAT_UNATTR_BIT 0
`define CCIL_LAT_LOOKA_BIT  1
`define CCIL_LAT_RIGHT_BIT  2
`define CCIL_LAT_LEFT_BIT   3

`define CCIL_CTL_MASTER_BIT 0
`define CCIL_CTL_ERRRST_BIT 1

`define CCIL_RIGHT_HALF 0
`define CCIL_LEFT_HALF  1

`define CCIL_WORD_ZERO 32'h0000_0000

`endif

/* File: ccil_pkg.sv */
package ccil_pkg;
	// bit 0 right half, bit 1 left half
	typedef logic [1:0]  ccil_half_t;
	// bit 0 first staging slot, bit 1 second staging slot
	typedef logic [1:0]  ccil_slot_t;
	typedef logic [3:0]  ccil_adr_t;
	typedef logic [3:0]  ccil_sel_t;
	typedef logic [31:0] ccil_word_t;
endpackage

/* File: ccil_half_if.sv */
`timescale 1ns/1ps
interface ccil_half_if;
	import ccil_pkg::*;
	ccil_half_t in_use;
	logic       attr_evt;
	logic       clear;
	logic       ce;
	logic       rst;
	ccil_half_t set;
	ccil_half_t latch;
	modport core (output in_use, output attr_evt, output clear, output ce, output rst, input set, input latch);
	modport half (input in_use, input attr_evt, input clear, input ce, input rst, output set, output latch);
endinterface

/* File: ccil_half_latches.sv */
`timescale 1ns/1ps
module ccil_half_latches
	import ccil_pkg::*;
(
	input  wire logic  clk_i,
	ccil_half_if.half  hif
);
	// ****************************************
	// per-half attributable check latches
	// ****************************************
	genvar h;
	generate
		for (h = 0; h < 2; h = h + 1)
		begin : g_half
			logic latch_ff;
			// only the half whose controls are active gets blamed
			assign hif.set[h] = hif.attr_evt & hif.in_use[h];
			always_ff @(posedge clk_i)
			begin
				if (hif.rst)
					latch_ff <= 1'b0;
				else if (hif.ce)
				begin
					if (hif.clear)
						latch_ff <= 1'b0;
					else if (hif.set[h])
						latch_ff <= 1'b1;
				end
			end
			assign hif.latch[h] = latch_ff;
		end
	endgenerate
endmodule

/* File: ccil_top.sv */
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "ccil_consts.svh"
module ccil_top
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire ccil_pkg::ccil_adr_t  wb_adr_i,
	input  wire ccil_pkg::ccil_sel_t  wb_sel_i,
	input  wire ccil_pkg::ccil_word_t wb_dat_i,
	output logic                      wb_ack_o,
	output ccil_pkg::ccil_word_t      wb_dat_o,
	input  wire logic                master_reset_i,
	input  wire logic                err_reset_i,
	input  wire ccil_pkg::ccil_half_t half_in_use_i,
	input  wire logic                ixadd_err_i,
	input  wire logic                ixadd_unattr_cond_i,
	input  wire logic                uncorr_err_i,
	input  wire logic                uncorr_unattr_cond_i,
	input  wire logic                uncorr_attr_cond_i,
	input  wire logic                ic_adv_err_i,
	input  wire logic                par_err_i,
	input  wire logic                par_unattr_cond_i,
	input  wire logic                par_attr_cond_i,
	input  wire logic                isa_chk_i,
	input  wire logic                isa_attr_cond_i,
	input  wire logic                mem_chk_i,
	input  wire logic                mem_unattr_cond_i,
	input  wire logic                sbc_par_err_i,
	input  wire logic                la_par_err_i,
	input  wire ccil_pkg::ccil_slot_t slot_attr_check_i,
	input  wire ccil_pkg::ccil_slot_t slot_xfer_i,
	output logic                      machine_fault_flag_o,
	output logic                      instruction_refused_flag_o,
	output logic                      unattributable_check_latch_o,
	output logic                      attributable_check_latch_o
);
	import ccil_pkg::*;

	// ****************************************
	// fault routing
	// ****************************************
	logic any_half;
	logic par_to_un;
	logic par_to_at;
	logic unc_to_un;
	logic unc_to_at;
	logic ixa_to_un;
	logic ixa_to_at;
	logic isa_to_un;
	logic isa_to_at;
	logic mem_to_un;
	logic mem_to_at;
	logic slot_evt;
	logic slot_to_un;
	logic slot_to_at;
	logic la_to_un;
	logic la_to_at;
	logic unattr_set;
	logic attr_evt;

	assign any_half   = |half_in_use_i;
	// unattributable qualification always wins so one event never reports twice
	assign par_to_un  = par_err_i & par_unattr_cond_i;
	assign par_to_at  = par_err_i & ~par_unattr_cond_i & par_attr_cond_i & any_half;
	assign unc_to_un  = uncorr_err_i & uncorr_unattr_cond_i;
	assign unc_to_at  = uncorr_err_i & ~uncorr_unattr_cond_i & uncorr_attr_cond_i & any_half;
	// with no half in use nobody can be blamed, so fall back to the machine check
	assign ixa_to_un  = ixadd_err_i & (ixadd_unattr_cond_i | ~any_half);
	assign ixa_to_at  = ixadd_err_i & ~ixadd_unattr_cond_i & any_half;
	assign isa_to_at  = isa_chk_i & isa_attr_cond_i & any_half;
	assign isa_to_un  = isa_chk_i & ~isa_to_at;
	assign mem_to_un  = mem_chk_i & (mem_unattr_cond_i | ~any_half);
	assign mem_to_at  = mem_chk_i & ~mem_unattr_cond_i & any_half;
	assign slot_evt   = |(slot_attr_check_i & slot_xfer_i);
	assign slot_to_at = slot_evt & any_half;
	assign slot_to_un = slot_evt & ~any_half;
	assign la_to_at   = la_par_err_i & any_half;
	assign la_to_un   = la_par_err_i & ~any_half;

	assign unattr_set = par_to_un | unc_to_un | ixa_to_un | isa_to_un | mem_to_un | slot_to_un | la_to_un
		| ic_adv_err_i | sbc_par_err_i;
	assign attr_evt   = par_to_at | unc_to_at | ixa_to_at | isa_to_at | mem_to_at | slot_to_at | la_to_at;

	// ****************************************
	// register bus
	// ****************************************
	logic       ack_ff;
	ccil_word_t dat_ff;
	logic       bus_req;
	logic       bus_wr;
	logic       wr_ind;
	logic       wr_ctl;
	logic       sw_master;
	logic       sw_errrst;
	logic       master_clr;
	logic       error_clr;
	logic       ind_fault_clr;
	logic       ind_refused_clr;
	ccil_word_t rd_word;

	assign bus_req = wb_cyc_i & wb_stb_i;
	// write lands at the edge where the master sees ack
	assign bus_wr  = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
	assign wr_ind  = bus_wr & (wb_adr_i == `CCIL_ADR_INDICATOR);
	assign wr_ctl  = bus_wr & (wb_adr_i == `CCIL_ADR_CONTROL);

	assign sw_master       = wr_ctl & wb_dat_i[`CCIL_CTL_MASTER_BIT];
	assign sw_errrst       = wr_ctl & wb_dat_i[`CCIL_CTL_ERRRST_BIT];
	assign master_clr      = master_reset_i | sw_master;
	assign error_clr       = master_clr | err_reset_i | sw_errrst;
	assign ind_fault_clr   = wr_ind & wb_dat_i[`CCIL_IND_FAULT_BIT];
	assign ind_refused_clr = wr_ind & wb_dat_i[`CCIL_IND_REFUSED_BIT];

	logic       unattr_ff;
	logic       looka_ff;
	logic       fault_ff;
	logic       refused_ff;
	ccil_half_t half_latch;
	ccil_half_t half_set;

	always_comb
	begin
		rd_word = `CCIL_WORD_ZERO;
		case (wb_adr_i)
			`CCIL_ADR_INDICATOR:
			begin
				rd_word[`CCIL_IND_FAULT_BIT]   = fault_ff;
				rd_word[`CCIL_IND_REFUSED_BIT] = refused_ff;
			end
			`CCIL_ADR_LATCHES:
			begin
				rd_word[`CCIL_LAT_UNATTR_BIT] = unattr_ff;
				rd_word[`CCIL_LAT_LOOKA_BIT]  = looka_ff;
				rd_word[`CCIL_LAT_RIGHT_BIT]  = half_latch[`CCIL_RIGHT_HALF];
				rd_word[`CCIL_LAT_LEFT_BIT]   = half_latch[`CCIL_LEFT_HALF];
			end
			// control is write-only pulses, unmapped reads answer zero
			default:
				rd_word = `CCIL_WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_ff <= 1'b0;
		else if (ce_i)
			ack_ff <= bus_req & ~ack_ff;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_ff <= `CCIL_WORD_ZERO;
		else if (ce_i && bus_req && !ack_ff)
			dat_ff <= rd_word;
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// ****************************************
	// check latches
	// ****************************************
	ccil_half_if hif ();
	assign hif.in_use   = half_in_use_i;
	assign hif.attr_evt = attr_evt;
	assign hif.clear    = error_clr;
	assign hif.ce       = ce_i;
	assign hif.rst      = rst_i;
	assign half_set     = hif.set;
	assign half_latch   = hif.latch;

	ccil_half_latches u_halves
	(
		.clk_i (clk_i),
		.hif   (hif.half)
	);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			unattr_ff <= 1'b0;
		else if (ce_i)
		begin
			if (error_clr)
				unattr_ff <= 1'b0;
			else if (unattr_set)
				unattr_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			looka_ff <= 1'b0;
		else if (ce_i)
		begin
			if (error_clr)
				looka_ff <= 1'b0;
			else if (|half_latch)
				looka_ff <= 1'b1;
		end
	end

	// ****************************************
	// indicator register
	// ****************************************
	// software clear loses to a new report in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fault_ff <= 1'b0;
		else if (ce_i)
		begin
			if (master_clr)
				fault_ff <= 1'b0;
			else if (unattr_ff)
				fault_ff <= 1'b1;
			else if (ind_fault_clr)
				fault_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			refused_ff <= 1'b0;
		else if (ce_i)
		begin
			if (master_clr)
				refused_ff <= 1'b0;
			else if (looka_ff)
				refused_ff <= 1'b1;
			else if (ind_refused_clr)
				refused_ff <= 1'b0;
		end
	end

	assign machine_fault_flag_o         = fault_ff;
	assign instruction_refused_flag_o   = refused_ff;
	assign unattributable_check_latch_o = unattr_ff;
	assign attributable_check_latch_o   = looka_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	unattr_set_a: assert property (ce_i && unattr_set && !error_clr |=> unattr_ff)
		else $error("unattributable latch missed a set");
	fault_flag_a: assert property (ce_i && unattr_ff && !master_clr |=> fault_ff)
		else $error("machine fault flag did not follow latch");
	refused_flag_a: assert property (ce_i && looka_ff && !master_clr |=> refused_ff)
		else $error("instruction refused flag did not follow latch");
	looka_chain_a: assert property (ce_i && attr_evt && any_half && !error_clr ##1 ce_i && !error_clr
		|=> looka_ff)
		else $error("attributable report did not reach lookahead in two cycles");
	route_once_a: assert property (!((par_to_un && par_to_at) || (unc_to_un && unc_to_at)
		|| (ixa_to_un && ixa_to_at) || (isa_to_un && isa_to_at) || (mem_to_un && mem_to_at)))
		else $error("one fault routed to both paths");
	ixadd_route_a: assert property (ixadd_err_i && !ixadd_unattr_cond_i && any_half
		|-> (half_set & half_in_use_i) != 2'b00)
		else $error("index adder error not attributed");
	isa_route_a: assert property (isa_chk_i && !(isa_attr_cond_i && any_half) |-> unattr_set)
		else $error("index address check lost");
	slot_route_a: assert property (slot_evt && any_half && !error_clr && ce_i
		|=> (half_latch & $past(half_in_use_i)) == $past(half_in_use_i))
		else $error("staging slot check not latched");
	master_clear_a: assert property (ce_i && master_clr
		|=> !fault_ff && !refused_ff && !unattr_ff && !looka_ff && half_latch == 2'b00)
		else $error("master reset left state set");
	err_clear_a: assert property (ce_i && error_clr && !master_clr && !wr_ind
		|=> !unattr_ff && !looka_ff && fault_ff == ($past(fault_ff) || $past(unattr_ff)))
		else $error("error reset misbehaved");
	bus_ack_a: assert property (ce_i && bus_req && !ack_ff |=> ack_ff ##1 !ack_ff || !ce_i)
		else $error("bus ack not one cycle");
endmodule

/* File: ccil_err_src.sv */
`timescale 1ns/1ps
module ccil_err_src
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,
	input  wire logic [18:0] vec_i,
	output logic      [18:0] lines_o
);
	// one cycle high is one fault event, so a request leaves as a single pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lines_o <= 19'h0_0000;
		else
			lines_o <= go_i ? vec_i : 19'h0_0000;
	end
endmodule

/* File: cpu_check_indicator_logic_tb.sv */
`timescale 1ns/1ps
module cpu_check_indicator_logic_tb;
	import ccil_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce    = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	ccil_adr_t   adr   = 4'h0;
	ccil_word_t  dat   = 32'h0000_0000;
	logic        ack;
	ccil_word_t  q;
	logic        mrst  = 1'b0;
	logic        erst  = 1'b0;
	ccil_half_t  half  = 2'h0;
	logic        go    = 1'b0;
	logic [18:0] vec   = 19'h0_0000;
	logic [18:0] ln;
	logic        mk, ij, ul, al;
	int          err_count  = 0;
	int          n_compared = 0;
	always #4 clk_i = ~clk_i;
	ccil_err_src src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .vec_i(vec), .lines_o(ln));
	ccil_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(q),
		.master_reset_i(mrst), .err_reset_i(erst), .half_in_use_i(half), .ixadd_err_i(ln[0]),
		.ixadd_unattr_cond_i(ln[1]), .uncorr_err_i(ln[2]), .uncorr_unattr_cond_i(ln[3]),
		.uncorr_attr_cond_i(ln[4]), .ic_adv_err_i(ln[5]), .par_err_i(ln[6]), .par_unattr_cond_i(ln[7]),
		.par_attr_cond_i(ln[8]), .isa_chk_i(ln[9]), .isa_attr_cond_i(ln[10]), .mem_chk_i(ln[11]),
		.mem_unattr_cond_i(ln[12]), .sbc_par_err_i(ln[13]), .la_par_err_i(ln[14]),
		.slot_attr_check_i(ln[16:15]), .slot_xfer_i(ln[18:17]), .machine_fault_flag_o(mk),
		.instruction_refused_flag_o(ij), .unattributable_check_latch_o(ul), .attributable_check_latch_o(al));
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			err_count++;
		end
	endtask
	// request stands until the edge that samples ack high; data is taken and the request dropped there
	task automatic wb(input logic w, input ccil_adr_t a, input ccil_word_t d, output ccil_word_t r);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = q;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	// one-cycle reset request: 0 master reset, 1 error-latch reset
	task automatic pulse(input logic err_kind);
		@(posedge clk_i);
		if (err_kind)
			erst <= 1'b1;
		else
			mrst <= 1'b1;
		@(posedge clk_i);
		mrst <= 1'b0;
		erst <= 1'b0;
	endtask
	task automatic fire(input logic [18:0] v, input ccil_half_t h, input logic eu, ea, input logic [1:0] erl);
		ccil_word_t r;
		pulse(1'b0);
		half <= h; vec <= v; go <= 1'b1;
		@(posedge clk_i) go <= 1'b0;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		chk("unattr latch", ul, eu);
		chk("attr latch", al, ea);
		chk("fault flag", mk, eu);
		chk("refused flag", ij, ea);
		wb(1'b0, 4'h4, 32'h0000_0000, r);
		chk("latch reg", r, {28'h000_0000, erl, ea, eu});
		wb(1'b0, 4'h0, 32'h0000_0000, r);
		chk("indicator", r, {29'h0000_0000, ea, 1'b0, eu});
		pulse(1'b1);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("err rst unattr", ul, 1'b0);
		chk("err rst attr", al, 1'b0);
		chk("err rst fault", mk, eu);
		chk("err rst refused", ij, ea);
	endtask
	// half controls in use everywhere: the unattributable qualifier must still win
	task automatic t_unattr();
		logic [18:0] v [7] = '{19'h0_0003, 19'h0_000C, 19'h0_0020, 19'h0_01C0, 19'h0_0200, 19'h0_1800, 19'h0_2000};
		foreach (v[i]) fire(v[i], 2'h3, 1'b1, 1'b0, 2'h0);
	endtask
	// last row: slot check paired with the other slot's transfer must stay silent
	task automatic t_attr();
		logic [18:0] v [8] = '{19'h0_0140, 19'h0_0014, 19'h0_0001, 19'h2_8000, 19'h0_4000, 19'h0_0600,
			19'h0_0800, 19'h4_8000};
		ccil_half_t  h [8] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
		for (int i = 0; i < 7; i++)
			fire(v[i], h[i], 1'b0, 1'b1, h[i]);
		fire(v[7], h[7], 1'b0, 1'b0, 2'h0);
	endtask
	task automatic t_regs();
		ccil_word_t r;
		wb(1'b0, 4'hC, 32'h0000_0000, r);
		chk("unmapped read", r, 32'h0000_0000);
		fire(19'h0_0020, 2'h0, 1'b1, 1'b0, 2'h0);
		wb(1'b1, 4'h0, 32'h0000_0001, r);
		wb(1'b0, 4'h0, 32'h0000_0000, r);
		chk("w1c indicator", r, 32'h0000_0000);
		fire(19'h0_4000, 2'h2, 1'b0, 1'b1, 2'h2);
		wb(1'b1, 4'h8, 32'h0000_0001, r);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("sw master rst", {mk, ij}, 2'h0);
		wb(1'b0, 4'h8, 32'h0000_0000, r);
		chk("control read", r, 32'h0000_0000);
	endtask
	// an event that arrives while the clock enable is low must leave no trace
	task automatic t_freeze();
		@(posedge clk_i) ce <= 1'b0;
		vec <= 19'h0_0020; go <= 1'b1;
		@(posedge clk_i) go <= 1'b0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("frozen latch", ul, 1'b0);
		@(posedge clk_i) ce <= 1'b1;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("frozen flag", mk, 1'b0);
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("reset flags", {mk, ij, ul, al}, 4'h0);
		t_unattr();
		t_attr();
		t_regs();
		t_freeze();
		end_sim();
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		end_sim();
	end
endmodule
